// *** verification/camera_control_io_timer_tb.sv ***
// self-checking bench for the camera control i/o block
// assumes ccio_pkg, ccio_top and the far-end model are compiled first
`timescale 1ns/1ps
module camera_control_io_timer_tb;
	import ccio_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, bounce;
	logic [31:0] wdata, rdata, rnd, rv, run_cnt, last_len;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs, ws;
	logic expo, rdw, ext_level, input_line, output_line, pulse_out;
	logic [15:0] strobes;
	int errors, checks;
	// -------------------------------------------------------------
	// design, far end, clock, monitor
	// -------------------------------------------------------------
	ccio_top dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.exposure_window(expo), .readout_window(rdw), .input_line(input_line),
		.output_line(output_line), .pulse_gen_output(pulse_out));
	ccio_far_end far_u (.aclk(aclk), .ext_level(ext_level), .bounce_cyc(bounce),
		.input_line(input_line), .output_line(output_line), .strobe_cnt_ff(strobes));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// length of the last high pulse, measured apart from the register reads
	always @(posedge aclk) begin
		if (pulse_out === 1'b1) run_cnt <= run_cnt + 32'h0000_0001;
		else begin
			if (run_cnt != 32'h0000_0000) last_len <= run_cnt;
			run_cnt <= 32'h0000_0000;
		end
	end
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic exp_line(logic [2:0] src, logic inv, logic lvl, logic e, logic r);
		logic s;
		case (src)
			CCIO_SRC_EXPO: s = e;
			CCIO_SRC_READ: s = r;
			CCIO_SRC_STAT: s = lvl;
			default: s = 1'b0;
		endcase
		return s ^ inv;
	endfunction : exp_line
	function automatic logic exp_trig(logic [2:0] cond, logic v);
		return (cond == CCIO_trig_rise) ? v : (cond == CCIO_trig_fall) ? ~v : 1'b1;
	endfunction : exp_trig
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		ws = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic set_src(input logic [1:0] ts, input logic v);
		@(posedge aclk);
		if (ts == CCIO_TS_EXPO) expo <= v;
		else if (ts == CCIO_TS_READ) rdw <= v;
		else ext_level <= v;
	endtask : set_src
	task automatic wait_out(input logic v, input int lim, output int n);
		n = 0;
		while (pulse_out !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask : wait_out
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// hang guard, about fourteen times the expected run
	initial begin
		repeat (60000) @(posedge aclk);
		errors++;
		report_and_stop();
	end
	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	initial begin
		int n, d, w;
		logic [2:0] src, cond;
		logic [1:0] ts;
		logic inv, lvl, act;
		logic [15:0] s0;
		logic [31:0] c0;
		{errors, checks} = 0;
		{run_cnt, last_len} = 0;
		rnd = 32'hceee_aa34;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, expo, rdw, ext_level} <= 9'h000;
		{awaddr, araddr, bounce, wdata, wstrb} <= '0;
		cyc(6);
		aresetn <= 1'b1;
		cyc(2);
		// reset contents, then an unmapped read
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4));
			if (i != 5) chk(rv, (i == 3) ? 32'h0000_0001 : 32'h0000_0000);
		end
		rd(8'h20);
		chk(32'(rs), 32'h0000_0002);
		wr(8'h20, 32'h0000_0000);
		chk(32'(ws), 32'h0000_0002);
		// every output source, random inversion, levels and windows
		for (int i = 0; i < 15; i++) begin
			rnd = lfsr(rnd);
			src = 3'(i % 5);
			inv = rnd[1];
			lvl = rnd[8];
			wr(CCIO_A_LINE, {23'h0, lvl, 1'b0, src, 2'h0, inv, 1'b1});
			expo <= rnd[9];
			rdw <= rnd[10];
			cyc(3);
			chk(32'(output_line), 32'(exp_line(src, inv, lvl, rnd[9], rnd[10])));
		end
		// input-line select and partial strobes leave the output alone
		lvl = output_line;
		wr(CCIO_A_LINE, 32'h0000_0132);
		wr(CCIO_A_LINE, 32'h0000_0133, 4'h3);
		cyc(3);
		chk(32'(output_line), 32'(lvl));
		// default filter: a 30-cycle glitch is lost, a held level passes late
		ext_level <= 1'b1;
		cyc(30);
		ext_level <= 1'b0;
		cyc(80);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0000);
		ext_level <= 1'b1;
		cyc(40);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0000);
		cyc(20);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0001);
		// 3 us filter with a chattering contact
		wr(CCIO_A_FILT, 32'h0000_0003);
		bounce <= 8'h14;
		ext_level <= 1'b0;
		cyc(150);
		ext_level <= 1'b1;
		cyc(50);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0001);
		ext_level <= 1'b0;
		cyc(180);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0001);
		cyc(160);
		rd(CCIO_A_STAT);
		chk(32'(rv[2]), 32'h0000_0000);
		wr(CCIO_A_FILT, 32'h000f_4241);
		rd(CCIO_A_FILT);
		chk(rv, 32'h0000_0003);
		wr(CCIO_A_FILT, 32'h000f_4240);
		rd(CCIO_A_FILT);
		chk(rv, 32'h000f_4240);
		wr(CCIO_A_FILT, 32'h0000_0000);
		bounce <= 8'h00;
		// edge modes, one trigger source each, random delay and width
		wr(CCIO_A_LINE, 32'h0000_0041);
		{expo, rdw} <= 2'b00;
		for (int c = 0; c < 3; c++) begin
			rnd = lfsr(rnd);
			d = rnd[1:0] % 3;
			w = 1 + rnd[3:2] % 3;
			ts = 2'(c + 1);
			cond = 3'(c);
			wr(CCIO_A_WIDTH, 32'(w));
			wr(CCIO_A_DELAY, 32'(d));
			wr(CCIO_A_TRIG, {25'h0, cond, 2'h0, ts});
			rd(CCIO_A_STAT);
			chk(32'(rv[1:0]), 32'(CCIO_STAT_WAIT));
			for (int v = 1; v >= 0; v--) begin
				s0 = strobes;
				set_src(ts, v[0]);
				if (exp_trig(cond, v[0])) begin
					wait_out(1'b1, 800, n);
					chk(32'(n >= d * 100 && n <= d * 100 + 110 + (c == 2 ? 70 : 0)), 1);
					rd(CCIO_A_STAT);
					chk(32'(rv[1:0]), 32'(CCIO_STAT_RUN));
					wait_out(1'b0, 400, n);
					cyc(3);
					chk(last_len, 32'(w * 100));
					chk(32'(strobes - s0), 32'h0000_0001);
					rd(CCIO_A_STAT);
					chk(32'(rv[1:0]), 32'(CCIO_STAT_WAIT));
				end else begin
					cyc(d * 100 + 300);
					chk(32'(strobes - s0), 32'h0000_0000);
				end
			end
		end
		// level modes hold past any width and drop with the source
		for (int c = 3; c < 5; c++) begin
			act = (c == 3);
			ts = act ? CCIO_TS_EXPO : CCIO_TS_READ;
			set_src(ts, ~act);
			wr(CCIO_A_DELAY, 32'h0000_0001);
			wr(CCIO_A_TRIG, {25'h0, 3'(c), 2'h0, ts});
			cyc(10);
			set_src(ts, act);
			wait_out(1'b1, 400, n);
			chk(32'(n >= 100 && n <= 210), 32'h0000_0001);
			cyc(350);
			chk(32'(pulse_out), 32'h0000_0001);
			set_src(ts, ~act);
			wait_out(1'b0, 4, n);
			chk(32'(pulse_out), 32'h0000_0000);
		end
		// count runs during the delay; restart in mid-pulse clears it
		wr(CCIO_A_WIDTH, 32'h0000_0003);
		wr(CCIO_A_DELAY, 32'h0000_0002);
		wr(CCIO_A_TRIG, {25'h0, CCIO_trig_rise, 2'h0, CCIO_TS_EXPO});
		set_src(CCIO_TS_EXPO, 1'b1);
		cyc(20);
		rd(CCIO_A_COUNT);
		c0 = rv;
		cyc(150);
		rd(CCIO_A_COUNT);
		chk(32'(rv != c0), 32'h0000_0001);
		wait_out(1'b1, 400, n);
		wr(CCIO_A_CMD, 32'h0000_0001);
		cyc(2);
		chk(32'(pulse_out), 32'h0000_0000);
		rd(CCIO_A_STAT);
		chk(32'(rv[1:0]), 32'(CCIO_STAT_WAIT));
		rd(CCIO_A_COUNT);
		chk(rv, 32'h0000_0000);
		set_src(CCIO_TS_EXPO, 1'b0);
		set_src(CCIO_TS_EXPO, 1'b1);
		wait_out(1'b1, 400, n);
		chk(32'(n >= 200 && n <= 310), 32'h0000_0001);
		// the running pulse finishes its width, then switching the source off returns to idle
		wait_out(1'b0, 400, n);
		chk(32'(pulse_out), 32'h0000_0000);
		wr(CCIO_A_TRIG, 32'h0000_0000);
		rd(CCIO_A_STAT);
		chk(32'(rv[1:0]), 32'(CCIO_STAT_IDLE));
		report_and_stop();
	end
endmodule : camera_control_io_timer_tb

// *** verification/ccio_far_end.sv ***
// far-end model: a trigger contact that chatters, and a strobe lamp
// assumes the bench sets the wanted contact level just after aclk rises
`timescale 1ns/1ps
module ccio_far_end (
	// clock
	input wire logic aclk,
	// trigger contact
	input wire logic ext_level,
	input wire logic [7:0] bounce_cyc,
	output logic input_line,
	// strobe lamp
	input wire logic output_line,
	output logic [15:0] strobe_cnt_ff
);
	logic [7:0] bounce_ff = 8'h00;
	logic last_ff = 1'b0;
	logic lamp_ff = 1'b0;
	initial input_line = 1'b0;
	initial strobe_cnt_ff = 16'h0000;
	// -------------------------------------------------------------
	// contact: chatter of one-cycle pulses after each change, then settle
	// -------------------------------------------------------------
	always @(posedge aclk) begin
		last_ff <= ext_level;
		if (ext_level != last_ff) begin
			bounce_ff <= bounce_cyc;
		end else if (bounce_ff != 8'h00) begin
			bounce_ff <= bounce_ff - 8'h01;
		end
		input_line <= (bounce_ff != 8'h00) ? ~input_line : ext_level;
	end
	// lamp: one flash per rising strobe, so extra pulses are seen
	always @(posedge aclk) begin
		lamp_ff <= output_line;
		if (output_line === 1'b1 && lamp_ff === 1'b0) strobe_cnt_ff <= strobe_cnt_ff + 16'h0001;
	end
endmodule : ccio_far_end

// *** verilog/ccio_pkg.sv ***
// constants for the camera control i/o and pulse generator block
// assumes a 100 MHz aclk and an axi4-lite master with 32-bit data
package ccio_pkg;
	// -------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [7:0] CCIO_A_LINE = 8'h00;
	localparam logic [7:0] CCIO_A_FILT = 8'h04;
	localparam logic [7:0] CCIO_A_TRIG = 8'h08;
	localparam logic [7:0] CCIO_A_WIDTH = 8'h0c;
	localparam logic [7:0] CCIO_A_DELAY = 8'h10;
	localparam logic [7:0] CCIO_A_CMD = 8'h14;
	localparam logic [7:0] CCIO_A_COUNT = 8'h18;
	localparam logic [7:0] CCIO_A_STAT = 8'h1c;
	// -------------------------------------------------------------
	// field positions of the line register
	// -------------------------------------------------------------
	localparam int CCIO_F_SEL = 0;
	localparam int CCIO_F_INV = 1;
	localparam int CCIO_F_SRC = 4;
	localparam int CCIO_F_LVL = 8;
	// -------------------------------------------------------------
	// encodings
	// -------------------------------------------------------------
	localparam logic [2:0] CCIO_SRC_OFF = 3'h0;
	localparam logic [2:0] CCIO_SRC_EXPO = 3'h1;
	localparam logic [2:0] CCIO_SRC_READ = 3'h2;
	localparam logic [2:0] CCIO_SRC_STAT = 3'h3;
	localparam logic [2:0] CCIO_SRC_PULSE = 3'h4;
	localparam logic [1:0] CCIO_TS_OFF = 2'h0;
	localparam logic [1:0] CCIO_TS_EXPO = 2'h1;
	localparam logic [1:0] CCIO_TS_READ = 2'h2;
	localparam logic [1:0] CCIO_TS_LINE = 2'h3;
	localparam logic [2:0] CCIO_trig_rise = 3'h0;
	localparam logic [2:0] CCIO_trig_fall = 3'h1;
	localparam logic [2:0] CCIO_trig_both_edges = 3'h2;
	localparam logic [2:0] CCIO_trig_while_high = 3'h3;
	localparam logic [2:0] CCIO_trig_while_low = 3'h4;
	// -------------------------------------------------------------
	// reset values and limits in microseconds, then clock and tick timing
	// -------------------------------------------------------------
	localparam logic [19:0] CCIO_FILT_MAX_US = 20'h0_F4240;
	localparam logic [25:0] CCIO_PULSE_MAX_US = 26'h393_8700;
	localparam logic [25:0] CCIO_WIDTH_RST = 26'h000_0001;
	localparam int CCIO_CLK_MHZ = 100;
	localparam int CCIO_TICK_NS = 1000;
	localparam int CCIO_CLK_NS = 10;
	localparam int CCIO_TICK_CYC = CCIO_TICK_NS / CCIO_CLK_NS;
	// default 0.5 us filter: half a tick, in clock cycles
	localparam int CCIO_FILT_RST_NS = 500;
	localparam int CCIO_FILT_RST_CYC = CCIO_FILT_RST_NS / CCIO_CLK_NS;
	// -------------------------------------------------------------
	// pulse generator states, one-hot
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		CCIO_ST_IDLE = 3'b001,
		CCIO_ST_WAIT = 3'b010,
		CCIO_ST_RUN = 3'b100
	} ccio_state_t;
	localparam logic [1:0] CCIO_STAT_IDLE = 2'h0;
	localparam logic [1:0] CCIO_STAT_WAIT = 2'h1;
	localparam logic [1:0] CCIO_STAT_RUN = 2'h2;
endpackage : ccio_pkg

// *** verilog/ccio_top.sv ***
// camera control i/o: filtered input line, one output line, pulse generator
// assumes an axi4-lite master on aclk; pins are asynchronous to aclk
`timescale 1ns/1ps
module ccio_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// camera timing, same clock domain
	input wire logic exposure_window,
	input wire logic readout_window,
	// pins
	input wire logic input_line,
	output logic output_line,
	output logic pulse_gen_output
);
	import ccio_pkg::*;

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	logic io_line_select_ff;
	logic output_invert_ff;
	logic [2:0] output_source_select_ff;
	logic static_level_value_ff;
	logic [19:0] glitch_filter_time_ff;
	logic [1:0] pulse_trig_source_ff;
	logic [2:0] pulse_trig_condition_ff;
	logic [25:0] pulse_width_us_ff;
	logic [25:0] pulse_delay_us_ff;
	logic pulse_gen_restart_ff;
	logic [25:0] pulse_gen_count_ff;
	ccio_state_t state_ff;
	logic filt_ff;

	// -------------------------------------------------------------
	// axi4-lite slave
	// -------------------------------------------------------------
	logic [7:0] awaddr_ff;
	logic aw_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_held_ff;
	logic do_wr;
	logic wr_ok;

	// address and data are caught independently; the write fires when both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held_ff <= 1'b0;
			end
		end
	end
	assign do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wr_ok = (awaddr_ff[7:5] == 3'h0) && (awaddr_ff[1:0] == 2'h0);

	// ready only while the holding slot is empty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; byte lane 0 carries every narrow field except the static level at bit 8
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_line_select_ff <= 1'b0;
			output_invert_ff <= 1'b0;
			output_source_select_ff <= CCIO_SRC_OFF;
			static_level_value_ff <= 1'b0;
			glitch_filter_time_ff <= 20'h0_0000;
			pulse_trig_source_ff <= CCIO_TS_OFF;
			pulse_trig_condition_ff <= CCIO_trig_rise;
			pulse_width_us_ff <= CCIO_WIDTH_RST;
			pulse_delay_us_ff <= 26'h000_0000;
			pulse_gen_restart_ff <= 1'b0;
		end else begin
			pulse_gen_restart_ff <= 1'b0;
			if (do_wr && wr_ok && (&wstrb_ff)) begin
				case (awaddr_ff)
					CCIO_A_LINE: begin
						io_line_select_ff <= wdata_ff[CCIO_F_SEL];
						// line settings apply only when this same write selects the output line (bit 0 set)
						if (wdata_ff[CCIO_F_SEL]) begin
							output_invert_ff <= wdata_ff[CCIO_F_INV];
							if (wdata_ff[CCIO_F_SRC +: 3] <= CCIO_SRC_PULSE) begin
								output_source_select_ff <= wdata_ff[CCIO_F_SRC +: 3];
							end
							static_level_value_ff <= wdata_ff[CCIO_F_LVL];
						end
					end
					CCIO_A_FILT: begin
						if (wdata_ff[19:0] <= CCIO_FILT_MAX_US) begin
							glitch_filter_time_ff <= wdata_ff[19:0];
						end
					end
					CCIO_A_TRIG: begin
						pulse_trig_source_ff <= wdata_ff[1:0];
						if (wdata_ff[6:4] <= CCIO_trig_while_low) begin
							pulse_trig_condition_ff <= wdata_ff[6:4];
						end
					end
					CCIO_A_WIDTH: begin
						if (wdata_ff[25:0] != 26'h000_0000
							&& wdata_ff[25:0] <= CCIO_PULSE_MAX_US) begin
							pulse_width_us_ff <= wdata_ff[25:0];
						end
					end
					CCIO_A_DELAY: begin
						if (wdata_ff[25:0] <= CCIO_PULSE_MAX_US) begin
							pulse_delay_us_ff <= wdata_ff[25:0];
						end
					end
					CCIO_A_CMD: pulse_gen_restart_ff <= wdata_ff[0];
					default: ;
				endcase
			end
		end
	end

	// read path: one cycle from address taken to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					CCIO_A_LINE: s_axi_rdata <= {23'h0, static_level_value_ff, 1'b0,
						output_source_select_ff, 2'h0, output_invert_ff, io_line_select_ff};
					CCIO_A_FILT: s_axi_rdata <= {12'h000, glitch_filter_time_ff};
					CCIO_A_TRIG: s_axi_rdata <= {25'h0, pulse_trig_condition_ff, 2'h0,
						pulse_trig_source_ff};
					CCIO_A_WIDTH: s_axi_rdata <= {6'h00, pulse_width_us_ff};
					CCIO_A_DELAY: s_axi_rdata <= {6'h00, pulse_delay_us_ff};
					CCIO_A_CMD: s_axi_rdata <= 32'h0000_0000;
					CCIO_A_COUNT: s_axi_rdata <= {6'h00, pulse_gen_count_ff};
					CCIO_A_STAT: s_axi_rdata <= {29'h0, filt_ff,
						(state_ff == CCIO_ST_RUN) ? CCIO_STAT_RUN :
						(state_ff == CCIO_ST_WAIT) ? CCIO_STAT_WAIT : CCIO_STAT_IDLE};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// microsecond tick
	// -------------------------------------------------------------
	logic [6:0] div_ff;
	logic tick;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff <= 7'h00;
		end else begin
			div_ff <= (tick) ? 7'h00 : div_ff + 7'h01;
		end
	end
	assign tick = (div_ff == 7'(CCIO_TICK_CYC - 1));

	// -------------------------------------------------------------
	// input line synchroniser and glitch filter
	// -------------------------------------------------------------
	logic sync1_ff;
	logic sync2_ff;
	logic [19:0] stab_us_ff;
	logic [6:0] stab_cyc_ff;
	logic stable_done;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= input_line;
			sync2_ff <= sync1_ff;
		end
	end

	// a zero filter time falls back to the half-microsecond floor; a set time counts
	// the shared free-running tick, so it can accept a level up to 1 us early
	assign stable_done = (glitch_filter_time_ff == 20'h0_0000)
		? (stab_cyc_ff >= 7'(CCIO_FILT_RST_CYC - 1))
		: (stab_us_ff >= glitch_filter_time_ff);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stab_us_ff <= 20'h0_0000;
			stab_cyc_ff <= 7'h00;
			filt_ff <= 1'b0;
		end else if (sync2_ff == filt_ff) begin
			// any return to the accepted level discards the candidate
			stab_us_ff <= 20'h0_0000;
			stab_cyc_ff <= 7'h00;
		end else if (stable_done) begin
			filt_ff <= sync2_ff;
			stab_us_ff <= 20'h0_0000;
			stab_cyc_ff <= 7'h00;
		end else begin
			if (stab_cyc_ff != 7'h7f) begin
				stab_cyc_ff <= stab_cyc_ff + 7'h01;
			end
			if (tick) begin
				stab_us_ff <= stab_us_ff + 20'h0_0001;
			end
		end
	end

	// -------------------------------------------------------------
	// pulse generator
	// -------------------------------------------------------------
	logic trig_sel;
	logic trig_prev_ff;
	logic trig_edge;
	logic lvl_mode;
	logic lvl_on;
	logic delay_done_ff;
	logic [6:0] pg_div_ff;
	logic pg_tick;
	logic delay_hit;
	always_comb begin
		case (pulse_trig_source_ff)
			CCIO_TS_EXPO: trig_sel = exposure_window;
			CCIO_TS_READ: trig_sel = readout_window;
			CCIO_TS_LINE: trig_sel = filt_ff;
			default: trig_sel = 1'b0;
		endcase
	end
	assign lvl_mode = (pulse_trig_condition_ff == CCIO_trig_while_high)
		|| (pulse_trig_condition_ff == CCIO_trig_while_low);
	assign lvl_on = (pulse_trig_condition_ff == CCIO_trig_while_high) ? trig_sel : !trig_sel;
	always_comb begin
		case (pulse_trig_condition_ff)
			CCIO_trig_rise: trig_edge = trig_sel && !trig_prev_ff;
			CCIO_trig_fall: trig_edge = !trig_sel && trig_prev_ff;
			CCIO_trig_both_edges: trig_edge = trig_sel != trig_prev_ff;
			default: trig_edge = 1'b0;
		endcase
	end

	// private microsecond phase, restarted at the trigger and at the end of the delay;
	// the shared free-running tick would let delay and width come up to 1 us short
	assign pg_tick = (pg_div_ff == 7'(CCIO_TICK_CYC - 1));
	assign delay_hit = !delay_done_ff && (pulse_gen_count_ff >= pulse_delay_us_ff);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pg_div_ff <= 7'h00;
		end else if ((state_ff != CCIO_ST_RUN) || pg_tick || delay_hit) begin
			pg_div_ff <= 7'h00;
		end else begin
			pg_div_ff <= pg_div_ff + 7'h01;
		end
	end

	// count runs through the delay, then through the width in edge modes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= CCIO_ST_IDLE;
			pulse_gen_count_ff <= 26'h000_0000;
			delay_done_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else begin
			trig_prev_ff <= trig_sel;
			if (pulse_gen_restart_ff) begin
				state_ff <= CCIO_ST_IDLE;
				pulse_gen_count_ff <= 26'h000_0000;
				delay_done_ff <= 1'b0;
			end else begin
				case (state_ff)
					CCIO_ST_IDLE: begin
						if (pulse_trig_source_ff != CCIO_TS_OFF) begin
							state_ff <= CCIO_ST_WAIT;
						end
					end
					CCIO_ST_WAIT: begin
						pulse_gen_count_ff <= 26'h000_0000;
						delay_done_ff <= 1'b0;
						if (pulse_trig_source_ff == CCIO_TS_OFF) begin
							state_ff <= CCIO_ST_IDLE;
						end else if (lvl_mode ? lvl_on : trig_edge) begin
							state_ff <= CCIO_ST_RUN;
						end
					end
					CCIO_ST_RUN: begin
						if (lvl_mode && !lvl_on) begin
							state_ff <= CCIO_ST_WAIT;
						end else if (!delay_done_ff) begin
							if (delay_hit) begin
								delay_done_ff <= 1'b1;
								pulse_gen_count_ff <= 26'h000_0000;
							end else if (pg_tick) begin
								pulse_gen_count_ff <= pulse_gen_count_ff + 26'h000_0001;
							end
						end else if (!lvl_mode && pg_tick) begin
							// width ends on its last whole microsecond, not one cycle later
							if (pulse_gen_count_ff >= pulse_width_us_ff - 26'h000_0001) begin
								state_ff <= CCIO_ST_WAIT;
							end else begin
								pulse_gen_count_ff <= pulse_gen_count_ff + 26'h000_0001;
							end
						end
					end
					default: state_ff <= CCIO_ST_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// output line
	// -------------------------------------------------------------
	logic pulse_on;
	logic src_val;
	assign pulse_on = (state_ff == CCIO_ST_RUN) && delay_done_ff
		&& (!lvl_mode || lvl_on);
	always_comb begin
		case (output_source_select_ff)
			CCIO_SRC_EXPO: src_val = exposure_window;
			CCIO_SRC_READ: src_val = readout_window;
			CCIO_SRC_STAT: src_val = static_level_value_ff;
			CCIO_SRC_PULSE: src_val = pulse_on;
			default: src_val = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_line <= 1'b0;
			pulse_gen_output <= 1'b0;
		end else begin
			output_line <= src_val ^ output_invert_ff;
			pulse_gen_output <= pulse_on;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	a_invert_path: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> output_line == ($past(src_val) ^ $past(output_invert_ff)))
		else $error("output line does not follow source and invert");
	a_static_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(output_source_select_ff == CCIO_SRC_STAT) && !output_invert_ff
		##1 (output_source_select_ff == CCIO_SRC_STAT) && !output_invert_ff
		|-> output_line == $past(static_level_value_ff))
		else $error("static level not driven");
	a_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync2_ff == filt_ff) |=> $stable(filt_ff))
		else $error("filtered input changed without a new level");
	a_no_pulse_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff != CCIO_ST_RUN) |=> !pulse_gen_output)
		else $error("pulse output while not running");
	a_restart_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		pulse_gen_restart_ff |=> state_ff == CCIO_ST_IDLE
		&& pulse_gen_count_ff == 26'h000_0000)
		else $error("restart did not clear the pulse generator");
	a_trig_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(pulse_trig_source_ff == CCIO_TS_OFF) [*2] |-> state_ff != CCIO_ST_RUN
		|| $past(state_ff) == CCIO_ST_RUN)
		else $error("pulse generator triggered with source off");
	a_level_drop: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == CCIO_ST_RUN) && lvl_mode && !lvl_on && !pulse_gen_restart_ff
		|=> state_ff == CCIO_ST_WAIT ##1 !pulse_gen_output)
		else $error("level mode output outlived its source");
	a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick [*8])
		else $error("microsecond tick too frequent");
	a_width_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_ff == CCIO_ST_RUN) && delay_done_ff && !lvl_mode && !pulse_gen_restart_ff
		&& pg_tick && (pulse_gen_count_ff >= pulse_width_us_ff - 26'h000_0001)
		|=> state_ff == CCIO_ST_WAIT)
		else $error("edge pulse did not end at its width");
	c_edge_pulse: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(pulse_gen_output) && !lvl_mode);
	c_level_pulse: cover property (@(posedge aclk) disable iff (!aresetn)
		$fell(pulse_gen_output) && lvl_mode);
	c_filter_rise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(filt_ff));
	c_restart: cover property (@(posedge aclk) disable iff (!aresetn)
		pulse_gen_restart_ff && state_ff == CCIO_ST_RUN);
endmodule : ccio_top
